// ### rtl/ecpx_cfg.svh
// offsets, field positions, codes and counts of the extended control logic
`ifndef ECPX_CFG_SVH
`define ECPX_CFG_SVH
`define ECPX_ADR_EXT_CTRL 3'h0
`define ECPX_ADR_DEV_CTRL 3'h1
`define ECPX_ADR_TEST_FIFO 3'h2
`define ECPX_ADR_CFG_A 3'h3
`define ECPX_ADR_CFG_B 3'h4
`define ECPX_ADR_IRQ_STAT 3'h5
`define ECPX_ADR_IRQ_MASK 3'h6
`define ECPX_MODE_HI 7
`define ECPX_MODE_LO 5
`define ECPX_BIT_ERR_MASK 4
`define ECPX_BIT_DMA_EN 3
`define ECPX_BIT_SERVICE 2
`define ECPX_BIT_FULL 1
`define ECPX_BIT_EMPTY 0
`define ECPX_BIT_DIR 5
`define ECPX_MODE_PP_FIFO 3'h2
`define ECPX_MODE_ECP 3'h3
`define ECPX_MODE_TEST 3'h6
`define ECPX_MODE_CONFIG 3'h7
`define ECPX_EXT_RESET 8'h05
`define ECPX_DEV_RESET 8'h00
`define ECPX_CFG_A_RESET 8'h10
`define ECPX_CFG_B_RESET 8'h00
`define ECPX_MASK_RESET 3'h0
`define ECPX_EV_SERVICE 0
`define ECPX_EV_ERROR 1
`define ECPX_EV_TC 2
`define ECPX_SVC_THRESH 8
`endif

// ### rtl/ecpx_pkg.sv
// types shared by the extended control logic
package ecpx_pkg;
   typedef logic [7:0] ecpx_byte_t;
   typedef logic [2:0] ecpx_event_t;
   typedef enum logic {ECPX_FWD, ECPX_BWD} ecpx_dir_t;
endpackage

// ### rtl/ecpx_extended_control.sv
// extended control register bank of the parallel port with events and interrupt
//
// Notes on behaviour
// - mode 110 selects FIFO test port
// - test mode issues no peripheral cycles
// - mode 111 exposes both config registers
// - unmasked fault falling edge raises interrupt unless clock frozen
// - unmasking during active fault raises interrupt
// - DMA enable off keeps request tri-stated
// - service event sets service bit, interrupts
// - terminal count is service event with DMA
// - without DMA, free/readable space by direction
// - service bit set suppresses service events
// - full bit reflects FIFO, read only
// - empty bit reflects FIFO, read only
// - frozen clock reads empty as one
// - eight bytes free/readable fires, even pending
// - level events masked while clock frozen
`timescale 1ns/100ps
`include "ecpx_cfg.svh"

module ecpx_extended_control
   import ecpx_pkg::*;
#(
   parameter int FIFO_DEPTH = 16,
   parameter int CNT_W = 5
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic fifoFull,
   input wire logic fifoEmpty,
   input wire logic [CNT_W-1:0] fifoCount,
   input wire logic [7:0] fifoRdData,
   output logic fifoPop,
   output logic fifoPush,
   output logic [7:0] fifoWrData,
   input wire logic faultN,
   input wire logic dmaTermCount,
   input wire logic clockFrozen,
   output logic dmaReq,
   output logic dmaReqOe,
   output logic cycleEnable,
   output logic fifoTestSel,
   output logic configSel,
   output logic [2:0] portMode,
   output logic portDirection,
   output logic irq
);

   // register state
   logic [2:0] mode_ff;
   logic errMask_ff;
   logic dmaEn_ff;
   logic service_ff;
   ecpx_byte_t devCtrl_ff;
   ecpx_byte_t cfgA_ff;
   ecpx_byte_t cfgB_ff;
   ecpx_event_t irqStat_ff;
   ecpx_event_t irqMask_ff;
   ecpx_byte_t rdData_ff;
   logic push_ff;
   ecpx_byte_t pushData_ff;
   logic faultPrev_ff;
   ecpx_dir_t dir;

   // reset image of the extended control register, sliced per field
   localparam ecpx_byte_t EXT_RST = `ECPX_EXT_RESET;

   // address decode, if-chain style through named wires
   logic hitExt, hitDev, hitTest, hitCfgA, hitCfgB, hitStat, hitMask;
   assign hitExt = regAddr == `ECPX_ADR_EXT_CTRL;
   assign hitDev = regAddr == `ECPX_ADR_DEV_CTRL;
   assign hitTest = regAddr == `ECPX_ADR_TEST_FIFO;
   assign hitCfgA = regAddr == `ECPX_ADR_CFG_A;
   assign hitCfgB = regAddr == `ECPX_ADR_CFG_B;
   assign hitStat = regAddr == `ECPX_ADR_IRQ_STAT;
   assign hitMask = regAddr == `ECPX_ADR_IRQ_MASK;

   // mode decode
   logic testMode, cfgMode, autoMode;
   assign testMode = mode_ff == `ECPX_MODE_TEST;
   assign cfgMode = mode_ff == `ECPX_MODE_CONFIG;
   assign autoMode = (mode_ff == `ECPX_MODE_PP_FIFO) || (mode_ff == `ECPX_MODE_ECP);
   assign dir = ecpx_dir_t'(devCtrl_ff[`ECPX_BIT_DIR]);

   // only automatic modes may run peripheral cycles
   assign cycleEnable = autoMode;
   assign fifoTestSel = testMode;
   assign configSel = cfgMode;
   assign portMode = mode_ff;
   assign portDirection = dir == ECPX_BWD;

   // fifo occupancy thresholds
   logic [CNT_W:0] freeCnt;
   logic freeEnough, readEnough;
   assign freeCnt = (CNT_W+1)'(FIFO_DEPTH) - {1'b0, fifoCount};
   assign freeEnough = freeCnt >= (CNT_W+1)'(`ECPX_SVC_THRESH);
   assign readEnough = {1'b0, fifoCount} >= (CNT_W+1)'(`ECPX_SVC_THRESH);

   // write and read strobes per register
   logic wrExt, wrTest, rdTest, rdStat;
   assign wrExt = regWrEn && hitExt;
   assign wrTest = regWrEn && hitTest && testMode;
   assign rdTest = regRdEn && hitTest && testMode;
   assign rdStat = regRdEn && hitStat;

   // service events
   logic tcEvt, fwdEvt, bwdEvt, fifoEvt, svcEvt;
   // terminal count counts only with DMA on
   assign tcEvt = dmaEn_ff && dmaTermCount;
   // level test, so a pending condition fires on clear
   assign fwdEvt = (dir == ECPX_FWD) && freeEnough && (autoMode || testMode);
   assign bwdEvt = (dir == ECPX_BWD) && readEnough
      && (mode_ff == `ECPX_MODE_ECP || testMode);
   assign fifoEvt = !dmaEn_ff && !clockFrozen && (fwdEvt || bwdEvt);
   // service bit set blocks all three
   assign svcEvt = !service_ff && (tcEvt || fifoEvt);

   // error events
   logic faultOn, faultFell, unmaskNow, errEvt;
   assign faultOn = !faultN;
   assign faultFell = faultPrev_ff && !faultN;
   assign unmaskNow = wrExt && errMask_ff && !regWrData[`ECPX_BIT_ERR_MASK];
   // frozen clock hides both the edge and the level event
   assign errEvt = !clockFrozen && ((!errMask_ff && faultFell) || (unmaskNow && faultOn));

   // event vector and sticky status
   ecpx_event_t evVec, nxt_irqStat;
   assign evVec = {tcEvt && !service_ff, errEvt, svcEvt};
   // set beats the clear-on-read in the same cycle
   assign nxt_irqStat = (rdStat ? '0 : irqStat_ff) | evVec;
   assign irq = |(irqStat_ff & irqMask_ff);

   // service bit: hardware set wins over software write
   logic nxt_service;
   assign nxt_service = svcEvt ? 1'b1
      : (wrExt ? regWrData[`ECPX_BIT_SERVICE] : service_ff);

   // request floats while DMA is off
   assign dmaReqOe = dmaEn_ff;
   assign dmaReq = dmaEn_ff && !service_ff && (autoMode || testMode)
      && ((dir == ECPX_FWD) ? !fifoFull : !fifoEmpty);

   // test port pops on host read only
   assign fifoPop = rdTest && !fifoEmpty;
   assign fifoPush = push_ff;
   assign fifoWrData = pushData_ff;

   // read mux, bits above the field read as zero
   ecpx_byte_t extView, nxt_rdData;
   // full is a live view, writes ignored
   // empty is a live view, writes ignored
   // frozen clock forces empty to one
   assign extView = {mode_ff, errMask_ff, dmaEn_ff, service_ff,
      fifoFull, fifoEmpty || clockFrozen};
   // config registers only visible in mode 111
   assign nxt_rdData = hitExt ? extView
      : hitDev ? devCtrl_ff
      : hitTest ? (testMode ? fifoRdData : 8'h00)
      : hitCfgA ? (cfgMode ? cfgA_ff : 8'h00)
      : hitCfgB ? (cfgMode ? cfgB_ff : 8'h00)
      : hitStat ? {5'h00, irqStat_ff}
      : hitMask ? {5'h00, irqMask_ff}
      : 8'h00;
   assign regRdData = rdData_ff;

   // extended control fields; full and empty are never stored
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_ff <= EXT_RST[`ECPX_MODE_HI:`ECPX_MODE_LO];
         errMask_ff <= EXT_RST[`ECPX_BIT_ERR_MASK];
         dmaEn_ff <= EXT_RST[`ECPX_BIT_DMA_EN];
      end else if (wrExt) begin
         mode_ff <= regWrData[`ECPX_MODE_HI:`ECPX_MODE_LO];
         errMask_ff <= regWrData[`ECPX_BIT_ERR_MASK];
         dmaEn_ff <= regWrData[`ECPX_BIT_DMA_EN];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         service_ff <= EXT_RST[`ECPX_BIT_SERVICE];
      end else begin
         service_ff <= nxt_service;
      end
   end

   // other writable registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         devCtrl_ff <= `ECPX_DEV_RESET;
         cfgA_ff <= `ECPX_CFG_A_RESET;
         cfgB_ff <= `ECPX_CFG_B_RESET;
         irqMask_ff <= `ECPX_MASK_RESET;
      end else if (regWrEn) begin
         if (hitDev) begin
            devCtrl_ff <= regWrData;
         end else if (hitCfgA && cfgMode) begin
            cfgA_ff <= regWrData;
         end else if (hitCfgB && cfgMode) begin
            cfgB_ff <= regWrData;
         end else if (hitMask) begin
            irqMask_ff <= regWrData[2:0];
         end
      end
   end

   // sticky status, fault history, read data, test push
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqStat_ff <= '0;
         faultPrev_ff <= 1'b1;
         rdData_ff <= 8'h00;
         push_ff <= 1'b0;
         pushData_ff <= 8'h00;
      end else begin
         irqStat_ff <= nxt_irqStat;
         faultPrev_ff <= faultN;
         rdData_ff <= regRdEn ? nxt_rdData : 8'h00;
         push_ff <= wrTest && !fifoFull;
         pushData_ff <= wrTest ? regWrData : pushData_ff;
      end
   end

   // checks on the block's own outputs and internal state
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence seqFaultEdge;
      !errMask_ff && !clockFrozen && faultFell;
   endsequence

   sequence seqUnmask;
      unmaskNow && faultOn && !clockFrozen;
   endsequence

   sequence seqBwdLevel;
      !service_ff && !dmaEn_ff && !clockFrozen && dir == ECPX_BWD && readEnough
         && (mode_ff == `ECPX_MODE_ECP || testMode);
   endsequence

   AST_TEST_QUIET: assert property (testMode |-> !cycleEnable && fifoTestSel)
      else $error("test mode runs peripheral cycles");
   AST_TEST_PUSH: assert property (wrTest && !fifoFull |=> fifoPush
      && fifoWrData == $past(regWrData))
      else $error("test port write did not push");
   AST_TEST_POP: assert property (rdTest && !fifoEmpty |-> fifoPop
      ##1 regRdData == $past(fifoRdData))
      else $error("test port read did not return the head");
   AST_CFG_HIDE: assert property (regRdEn && hitCfgA && !cfgMode |=> regRdData == 8'h00)
      else $error("config register visible outside mode 111");
   AST_ERR_EDGE: assert property (seqFaultEdge |=> irqStat_ff[`ECPX_EV_ERROR])
      else $error("fault edge gave no error status");
   AST_ERR_MASKED: assert property (errMask_ff && !wrExt |-> !errEvt)
      else $error("error event while mask set");
   AST_ERR_UNMASK: assert property (seqUnmask |=> irqStat_ff[`ECPX_EV_ERROR]
      && !errMask_ff)
      else $error("unmask with active fault lost");
   AST_DMA_FLOAT: assert property (!dmaEn_ff |-> !dmaReqOe && !dmaReq)
      else $error("request driven while DMA off");
   AST_DMA_HOLD: assert property (service_ff |-> !dmaReq)
      else $error("DMA request while service bit set");
   AST_SVC_SET: assert property (!service_ff && svcEvt |=> service_ff
      && irqStat_ff[`ECPX_EV_SERVICE])
      else $error("service event did not set service bit");
   AST_IRQ_OUT: assert property (irqStat_ff[`ECPX_EV_SERVICE]
      && irqMask_ff[`ECPX_EV_SERVICE] |-> irq)
      else $error("unmasked service status without interrupt");
   AST_TC_EVT: assert property (dmaEn_ff && dmaTermCount && !service_ff
      |=> service_ff && irqStat_ff[`ECPX_EV_TC])
      else $error("terminal count not taken");
   AST_FIFO_FWD: assert property (!service_ff && !dmaEn_ff && !clockFrozen && autoMode
      && dir == ECPX_FWD && freeEnough |=> service_ff)
      else $error("free space event missed");
   AST_FIFO_BWD: assert property (seqBwdLevel |=> service_ff
      && irqStat_ff[`ECPX_EV_SERVICE])
      else $error("readable bytes event missed");
   AST_SVC_QUIET: assert property (service_ff && !wrExt
      |=> $stable(irqStat_ff[`ECPX_EV_SERVICE]) || !irqStat_ff[`ECPX_EV_SERVICE])
      else $error("service event while service bit set");
   AST_FULL_VIEW: assert property (regRdEn && hitExt
      |=> regRdData[`ECPX_BIT_FULL] == $past(fifoFull))
      else $error("full bit does not follow fifo");
   AST_EMPTY_VIEW: assert property (regRdEn && hitExt && !clockFrozen
      |=> regRdData[`ECPX_BIT_EMPTY] == $past(fifoEmpty))
      else $error("empty bit does not follow fifo");
   AST_EMPTY_FROZEN: assert property (regRdEn && hitExt && clockFrozen
      |=> regRdData[`ECPX_BIT_EMPTY])
      else $error("frozen clock empty bit not one");
   AST_PENDING: assert property ($fell(service_ff) && fifoEvt |=> service_ff)
      else $error("pending fifo level lost on clear");
   AST_FROZEN_MASK: assert property (clockFrozen |-> !errEvt && !fifoEvt)
      else $error("level event while frozen");

endmodule

// ### testbench/ecpx_fifo_model.sv
// fifo partner model seen by the extended control logic
`timescale 1ns/100ps
module ecpx_fifo_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic push,
   input wire logic pop,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData,
   output logic full,
   output logic empty,
   output logic [4:0] count
);
   logic [7:0] q [$];
   // outputs move by nba so the block samples the old state
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         q = {};
         rdData <= 8'h5A;
      end else begin
         if (pop && q.size() > 0)
            void'(q.pop_front());
         if (push && q.size() < 16)
            q.push_back(wrData);
         // empty head toggles between the last byte and its inverse
         rdData <= (q.size() > 0) ? q[0] : ~rdData;
      end
      full <= (q.size() == 16);
      empty <= (q.size() == 0);
      count <= 5'(q.size());
   end
endmodule

// ### testbench/tb_top.sv
// self-checking bench of the extended control register bank
`timescale 1ns/100ps
`include "ecpx_cfg.svh"
module tb_top;
   import ecpx_pkg::*;
   localparam logic [2:0] EC = `ECPX_ADR_EXT_CTRL;
   localparam logic [2:0] DC = `ECPX_ADR_DEV_CTRL;
   localparam logic [2:0] TF = `ECPX_ADR_TEST_FIFO;
   localparam logic [2:0] IS = `ECPX_ADR_IRQ_STAT;
   localparam logic [2:0] IM = `ECPX_ADR_IRQ_MASK;
   logic clock, rst, regWrEn, regRdEn, faultN, dmaTermCount, clockFrozen;
   logic fifoFull, fifoEmpty, fifoPop, fifoPush, dmaReq, dmaReqOe, cycleEnable;
   logic fifoTestSel, configSel, portDirection, irq;
   logic [2:0] regAddr, portMode;
   logic [7:0] regWrData, regRdData, fifoRdData, fifoWrData;
   logic [4:0] fifoCount;
   int n_errors = 0;
   int n_checks = 0;

   ecpx_extended_control uut (
      .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .fifoFull(fifoFull), .fifoEmpty(fifoEmpty), .fifoCount(fifoCount),
      .fifoRdData(fifoRdData), .fifoPop(fifoPop), .fifoPush(fifoPush),
      .fifoWrData(fifoWrData), .faultN(faultN), .dmaTermCount(dmaTermCount),
      .clockFrozen(clockFrozen), .dmaReq(dmaReq), .dmaReqOe(dmaReqOe),
      .cycleEnable(cycleEnable), .fifoTestSel(fifoTestSel), .configSel(configSel),
      .portMode(portMode), .portDirection(portDirection), .irq(irq)
   );
   ecpx_fifo_model fifo (
      .clock(clock), .rst(rst), .push(fifoPush), .pop(fifoPop), .wrData(fifoWrData),
      .rdData(fifoRdData), .full(fifoFull), .empty(fifoEmpty), .count(fifoCount)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // wr, rd and idle leave 1 ns after an edge, so strobes never race it
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clock);
      regWrEn <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clock);
      regRdEn <= 1'b0;
      #1;
      chk(regRdData & m, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // run needs about 125 cycles; allow ample margin
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 3'h0;
      regWrData = 8'h00;
      faultN = 1'b1;
      dmaTermCount = 1'b0;
      clockFrozen = 1'b0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      idle(1);
      rd(EC, `ECPX_EXT_RESET);
      chk(8'(dmaReqOe), 8'h00);
      rd(`ECPX_ADR_CFG_A, 8'h00);
      rd(3'h7, 8'h00);
      wr(EC, 8'hF4);
      chk(8'(configSel), 8'h01);
      rd(`ECPX_ADR_CFG_A, `ECPX_CFG_A_RESET);
      // test mode: fill past full, then drain
      wr(EC, 8'hD4);
      chk({6'h00, fifoTestSel, cycleEnable}, 8'h02);
      chk(8'(portMode), 8'(`ECPX_MODE_TEST));
      for (int i = 0; i < 17; i++)
         wr(TF, 8'(8'h30 + i));
      idle(2);
      rd(EC, 8'hD6);
      wr(EC, 8'hD5);
      rd(EC, 8'hD6);
      for (int i = 0; i < 16; i++)
         rd(TF, 8'(8'h30 + i));
      idle(1);
      rd(EC, 8'hD5);
      // forward service event with 16 free
      wr(IM, 8'h01);
      rd(IM, 8'h01);
      wr(EC, 8'hD0);
      idle(2);
      chk(8'(irq), 8'h01);
      rd(EC, 8'hD5);
      rd(IS, 8'h01);
      idle(2);
      rd(IS, 8'h00);
      chk(8'(irq), 8'h00);
      // backward: fires only at eight readable
      wr(DC, 8'h20);
      chk(8'(portDirection), 8'h01);
      wr(EC, 8'hD0);
      idle(2);
      rd(IS, 8'h00);
      for (int i = 0; i < 8; i++)
         wr(TF, 8'(i));
      idle(2);
      rd(IS, 8'h01);
      clockFrozen <= 1'b1;
      rd(EC, 8'h01, 8'h01);
      wr(EC, 8'hD0);
      idle(2);
      rd(IS, 8'h00);
      clockFrozen <= 1'b0;
      idle(2);
      rd(IS, 8'h01);
      for (int i = 0; i < 8; i++)
         rd(TF, 8'(i));
      // dma in ecp mode, forward, terminal count
      wr(DC, 8'h00);
      // plain fifo mode, forward, free space already pending
      wr(EC, 8'h50);
      chk(8'(cycleEnable), 8'h01);
      idle(1);
      rd(IS, 8'h01);
      wr(IM, 8'h07);
      wr(EC, 8'h7C);
      chk({6'h00, dmaReqOe, cycleEnable}, 8'h03);
      wr(EC, 8'h78);
      chk(8'(dmaReq), 8'h01);
      dmaTermCount <= 1'b1;
      idle(1);
      dmaTermCount <= 1'b0;
      idle(2);
      rd(IS, 8'h04, 8'h04);
      rd(EC, 8'h7D);
      chk(8'(dmaReq), 8'h00);
      // fault edges and unmasking with fault held
      wr(EC, 8'h6C);
      faultN <= 1'b0;
      idle(3);
      chk(8'(irq), 8'h01);
      rd(IS, 8'h02, 8'h02);
      wr(EC, 8'h7C);
      faultN <= 1'b1;
      idle(2);
      faultN <= 1'b0;
      idle(2);
      rd(IS, 8'h00, 8'h02);
      wr(EC, 8'h6C);
      idle(2);
      rd(IS, 8'h02, 8'h02);
      clockFrozen <= 1'b1;
      wr(EC, 8'h7C);
      wr(EC, 8'h6C);
      idle(2);
      rd(IS, 8'h00, 8'h02);
      give_verdict();
   end
endmodule
